// [hdl/acs_pkg.sv]
// Shared constants for the conversion sequencer: register map, fields, resets, timing
package acs_pkg;
  // Register byte offsets
  localparam logic [7:0] ACS_OFF_CTRL    = 8'h00;  // Enable, continuous, resolution
  localparam logic [7:0] ACS_OFF_ACCUM   = 8'h04;  // Accumulation count, delay, random
  localparam logic [7:0] ACS_OFF_CLKREF  = 8'h08;  // Reference and divider select
  localparam logic [7:0] ACS_OFF_MUX     = 8'h0c;  // Input channel select
  localparam logic [7:0] ACS_OFF_EVCTRL  = 8'h10;  // Trigger event input enable
  localparam logic [7:0] ACS_OFF_INTEN   = 8'h14;  // Interrupt enables
  localparam logic [7:0] ACS_OFF_COMMAND = 8'h18;  // Start conversion bit
  localparam logic [7:0] ACS_OFF_INTERRUPT_FLAG_REGISTER = 8'h1c;  // Interrupt flag register
  localparam logic [7:0] ACS_OFF_RESULT  = 8'h20;  // Conversion result
  localparam logic [7:0] ACS_OFF_WINLO   = 8'h24;  // Window low threshold
  localparam logic [7:0] ACS_OFF_WINHI   = 8'h28;  // Window high threshold
  localparam logic [7:0] ACS_OFF_WINMODE = 8'h2c;  // Window compare mode
  localparam logic [7:0] ACS_OFF_STATUS  = 8'h30;  // Applied channel, reference, busy
  // Field positions
  localparam int ACS_BIT_ENABLE  = 0;
  localparam int ACS_BIT_CONTINUOUS_MODE_BIT = 1;
  localparam int ACS_BIT_RESOLUTION_SELECT  = 2;
  localparam int ACS_POS_DLY     = 4;
  localparam int ACS_BIT_RANDOM  = 8;
  localparam int ACS_POS_CLOCK_DIVIDER_SELECT   = 4;
  localparam int ACS_BIT_RESULT_READY_FLAG  = 0;
  localparam int ACS_BIT_WCMP    = 1;
  localparam int ACS_POS_APPREF  = 8;
  localparam int ACS_BIT_BUSY    = 16;
  // Reset values
  localparam logic [1:0] ACS_REFERENCE_SELECT_RST = 2'h0;   // Internal reference generator
  localparam logic [2:0] ACS_CLOCK_DIVIDER_SELECT_RST  = 3'h0;
  localparam logic [4:0] ACS_MUX_RST    = 5'h00;
  localparam logic [7:0] ACS_LFSR_RST   = 8'h01;  // Any non-zero seed
  // Timing and sizes
  localparam logic [3:0] ACS_CONV_CLKS  = 4'd13;  // Converter clocks per conversion
  localparam logic [3:0] ACS_SH_CLK     = 4'd1;   // Sample-and-hold after start
  localparam logic [2:0] ACS_ACC_MAXLOG = 3'd6;   // At most 64 samples
  // Window compare modes
  localparam logic [2:0] ACS_WIN_OFF = 3'd0;
  localparam logic [2:0] ACS_WIN_BELOW = 3'd1;
  localparam logic [2:0] ACS_WIN_ABOVE = 3'd2;
  localparam logic [2:0] ACS_WIN_INSIDE = 3'd3;
  localparam logic [2:0] ACS_WIN_OUTSIDE = 3'd4;
  // Sequencer states
  typedef enum logic [1:0] {ACS_IDLE, ACS_ARM, ACS_CONV, ACS_DELAY} acs_state_t;
endpackage

// [hdl/acs_clock_divider_select.sv]
// Converter clock divider producing one tick per converter clock period
`timescale 1ns/1ps
module acs_clock_divider_select
  import acs_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       resetn,
  input  wire logic       ce,
  input  wire logic       run,
  input  wire logic [2:0] div_sel,
  output logic            tick
);
  logic [7:0] cnt_q, cnt_d;  // Divider counter
  logic       tick_d;        // Next tick
  logic [7:0] lim;           // Terminal count, divide by 2 to 256

  // Count while enabled, held at zero otherwise
  always_comb begin
    lim    = 8'((9'd2 << div_sel) - 9'd1);
    cnt_d  = 8'h00;
    tick_d = 1'b0;
    if (run) begin
      cnt_d  = (cnt_q == lim) ? 8'h00 : 8'(cnt_q + 8'h01);
      tick_d = (cnt_q == lim);
    end
  end

  // Register only
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 8'h00;
      tick  <= 1'b0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      tick  <= tick_d;
    end
  end
endmodule

// [hdl/acs_seq.sv]
// Conversion sequencer: APB registers, start logic, accumulation, window compare
// How it works
// - Result is 10 bits, right aligned
// - Selections apply and run only when enabled
// - Start bit reads one while converting
// - Single mode clears start bit when done
// - Channel change waits for current conversion
// - Ready flag set when whole operation ends
// - Interrupt needs flag, enable and global enable
// - Ready flag set even with interrupt off
// - Enabled event input starts a conversion
// - Event edge sets start bit, done clears
// - Continuous mode restarts and flags each completion
// - Accumulate up to 64 samples per result
// - Sample delay with optional random variation
// - Window compare below, above, inside, outside
// - Channel select covers pins and internals
// - Reference: internal, supply or external pin
// - Reference resets to internal generator
// - One conversion takes 13 converter clocks
// - Result read or write-one clears flag
// - Divider held at zero while disabled
// - Start waits for next converter clock edge
//
// Local design decisions: the address map and register access over APB.
`timescale 1ns/1ps
module acs_seq
  import acs_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        ce,               // Freezes all state when low
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        trig_evt,         // Event router trigger, asynchronous
  input  wire logic        gie,              // Global interrupt enable
  input  wire logic [9:0]  conv_data,        // Converter output, same clock
  output logic      [4:0]  applied_channel,  // Channel driven to the input mux
  output logic      [1:0]  applied_ref,      // Reference driven to the converter
  output logic             converter_on,     // Analog power enable
  output logic             sample_hold,      // One-cycle sample-and-hold pulse
  output logic             irq
);
  // Configuration registers
  logic        enable_q, continuous_mode_bit_q, resolution_select_q, random_q, trigger_event_input_enable_q;
  logic [2:0]  accum_q, clock_divider_select_q, winmode_q;
  logic [3:0]  sampdly_q;
  logic [1:0]  reference_select_q, inten_q;
  logic [4:0]  input_channel_select_q;
  logic [15:0] winlo_q, winhi_q;
  logic        enable_d, continuous_mode_bit_d, resolution_select_d, random_d, trigger_event_input_enable_d;
  logic [2:0]  accum_d, clock_divider_select_d, winmode_d;
  logic [3:0]  sampdly_d;
  logic [1:0]  reference_select_d, inten_d;
  logic [4:0]  input_channel_select_d;
  logic [15:0] winlo_d, winhi_d;
  // Sequencer and status
  acs_state_t  state_q, state_d;
  logic        start_conversion_bit_q, start_conversion_bit_d, done_q, done_d, sh_d, irq_d;
  logic        stop_q, stop_d;                  // Stop asked for a continuous run
  logic [1:0]  flag_q, flag_d, app_ref_d;
  logic [15:0] res_q, res_d, acc_q, acc_d, sum;
  logic [3:0]  tcnt_q, tcnt_d;
  logic [6:0]  samp_q, samp_d;
  logic [4:0]  dly_q, dly_d, app_ch_d, dly_new;
  logic [7:0]  lfsr_q, lfsr_d;
  logic [9:0]  sample;                          // Sample after resolution select
  // Bus and event
  logic [31:0] prdata_d;
  logic        pready_d, pslverr_d, wr, rd, start_req, tick;
  logic        evt_s1, evt_s2, evt_s3;          // Event synchroniser and edge history

  assign wr = psel && penable && pready && pwrite;   // Write completes here
  assign rd = psel && penable && pready && !pwrite;  // Read completes here

  // Write strobe for one register
  function automatic logic wr_at(input logic w, input logic [7:0] a, input logic [7:0] off);
    return w && (a == off);
  endfunction

  // Samples per burst, clamped at 64
  function automatic logic [6:0] burst_len(input logic [2:0] n);
    return (n > ACS_ACC_MAXLOG) ? 7'd64 : 7'(7'd1 << n);
  endfunction

  // Window test on a finished result
  function automatic logic win_hit(input logic [2:0] m, input logic [15:0] v,
                                   input logic [15:0] lo, input logic [15:0] hi);
    unique case (m)
      ACS_WIN_BELOW:   return v < lo;
      ACS_WIN_ABOVE:   return v > hi;
      ACS_WIN_INSIDE:  return (v >= lo) && (v <= hi);
      ACS_WIN_OUTSIDE: return (v < lo) || (v > hi);
      default:         return 1'b0;  // Off and unused codes never hit
    endcase
  endfunction

  // Converter clock divider, runs only while enabled
  acs_clock_divider_select u_clock_divider_select (
    .mclk    (mclk),
    .resetn  (resetn),
    .ce      (ce),
    .run     (enable_q),
    .div_sel (clock_divider_select_q),
    .tick    (tick)
  );

  // Configuration writes
  always_comb begin
    enable_d  = enable_q;
    continuous_mode_bit_d = continuous_mode_bit_q;
    resolution_select_d  = resolution_select_q;
    accum_d   = accum_q;
    sampdly_d = sampdly_q;
    random_d  = random_q;
    reference_select_d  = reference_select_q;
    clock_divider_select_d   = clock_divider_select_q;
    input_channel_select_d  = input_channel_select_q;
    trigger_event_input_enable_d = trigger_event_input_enable_q;
    inten_d   = inten_q;
    winlo_d   = winlo_q;
    winhi_d   = winhi_q;
    winmode_d = winmode_q;
    if (wr_at(wr, paddr, ACS_OFF_CTRL)) begin
      enable_d  = pwdata[ACS_BIT_ENABLE];
      continuous_mode_bit_d = pwdata[ACS_BIT_CONTINUOUS_MODE_BIT];
      resolution_select_d  = pwdata[ACS_BIT_RESOLUTION_SELECT];
    end
    if (wr_at(wr, paddr, ACS_OFF_ACCUM)) begin
      accum_d   = pwdata[2:0];
      sampdly_d = pwdata[ACS_POS_DLY +: 4];
      random_d  = pwdata[ACS_BIT_RANDOM];
    end
    if (wr_at(wr, paddr, ACS_OFF_CLKREF)) begin
      reference_select_d = pwdata[1:0];
      clock_divider_select_d  = pwdata[ACS_POS_CLOCK_DIVIDER_SELECT +: 3];
    end
    if (wr_at(wr, paddr, ACS_OFF_MUX)) input_channel_select_d = pwdata[4:0];
    if (wr_at(wr, paddr, ACS_OFF_EVCTRL)) trigger_event_input_enable_d = pwdata[0];
    if (wr_at(wr, paddr, ACS_OFF_INTEN)) inten_d = pwdata[1:0];
    if (wr_at(wr, paddr, ACS_OFF_WINLO)) winlo_d = pwdata[15:0];
    if (wr_at(wr, paddr, ACS_OFF_WINHI)) winhi_d = pwdata[15:0];
    if (wr_at(wr, paddr, ACS_OFF_WINMODE)) winmode_d = pwdata[2:0];
  end

  // Configuration registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable_q  <= 1'b0;
      continuous_mode_bit_q <= 1'b0;
      resolution_select_q  <= 1'b0;
      accum_q   <= 3'h0;
      sampdly_q <= 4'h0;
      random_q  <= 1'b0;
      reference_select_q  <= ACS_REFERENCE_SELECT_RST;
      clock_divider_select_q   <= ACS_CLOCK_DIVIDER_SELECT_RST;
      input_channel_select_q  <= ACS_MUX_RST;
      trigger_event_input_enable_q <= 1'b0;
      inten_q   <= 2'h0;
      winlo_q   <= 16'h0000;
      winhi_q   <= 16'h0000;
      winmode_q <= ACS_WIN_OFF;
    end else if (ce) begin
      enable_q  <= enable_d;
      continuous_mode_bit_q <= continuous_mode_bit_d;
      resolution_select_q  <= resolution_select_d;
      accum_q   <= accum_d;
      sampdly_q <= sampdly_d;
      random_q  <= random_d;
      reference_select_q  <= reference_select_d;
      clock_divider_select_q   <= clock_divider_select_d;
      input_channel_select_q  <= input_channel_select_d;
      trigger_event_input_enable_q <= trigger_event_input_enable_d;
      inten_q   <= inten_d;
      winlo_q   <= winlo_d;
      winhi_q   <= winhi_d;
      winmode_q <= winmode_d;
    end
  end

  // Sequencer next state; flag clears are applied before flag sets so a set wins
  always_comb begin
    state_d   = state_q;
    start_conversion_bit_d  = start_conversion_bit_q;
    stop_d    = stop_q;
    done_d    = 1'b0;
    sh_d      = 1'b0;
    flag_d    = flag_q;
    res_d     = res_q;
    acc_d     = acc_q;
    tcnt_d    = tcnt_q;
    samp_d    = samp_q;
    dly_d     = dly_q;
    app_ch_d  = applied_channel;
    app_ref_d = applied_ref;
    lfsr_d    = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    // 8-bit mode keeps the top bits, still right aligned
    sample    = resolution_select_q ? {2'b00, conv_data[9:2]} : conv_data;
    sum       = 16'(acc_q + {6'h00, sample});
    dly_new   = 5'({1'b0, sampdly_q} + (random_q ? {1'b0, lfsr_q[3:0]} : 5'h00));
    start_req = enable_q && (
                (wr_at(wr, paddr, ACS_OFF_COMMAND) && pwdata[0])
                || (trigger_event_input_enable_q && evt_s2 && !evt_s3));
    if (wr_at(wr, paddr, ACS_OFF_INTERRUPT_FLAG_REGISTER)) flag_d = flag_q & ~pwdata[1:0];
    if (rd && paddr == ACS_OFF_RESULT) flag_d[ACS_BIT_RESULT_READY_FLAG] = 1'b0;
    // Writing zero ends a continuous run after the current result; busy stays high till then
    if (wr_at(wr, paddr, ACS_OFF_COMMAND) && !pwdata[0] && state_q != ACS_IDLE)
      stop_d = 1'b1;
    unique case (state_q)
      ACS_IDLE: begin
        if (enable_q) begin
          app_ch_d  = input_channel_select_q;
          app_ref_d = reference_select_q;
        end
        if (start_req) begin  // Only an idle sequencer takes a start
          start_conversion_bit_d = 1'b1;
          stop_d   = 1'b0;
          state_d  = ACS_ARM;
        end
      end
      ACS_ARM: begin
        // Wait for the converter clock edge; later starts are dropped
        if (tick) begin
          state_d = ACS_CONV;
          tcnt_d  = 4'h0;
          acc_d   = 16'h0000;
          samp_d  = 7'd0;
        end
      end
      ACS_CONV: begin
        if (tick) begin
          sh_d   = (tcnt_q == ACS_SH_CLK);
          tcnt_d = 4'(tcnt_q + 4'h1);
          if (tcnt_q == ACS_CONV_CLKS - 4'h1) begin
            acc_d  = sum;
            samp_d = 7'(samp_q + 7'd1);
            tcnt_d = 4'h0;
            if (7'(samp_q + 7'd1) == burst_len(accum_q)) begin
              res_d = sum;
              done_d = 1'b1;
              flag_d[ACS_BIT_RESULT_READY_FLAG] = 1'b1;
              if (win_hit(winmode_q, sum, winlo_q, winhi_q))
                flag_d[ACS_BIT_WCMP] = 1'b1;
              app_ch_d  = input_channel_select_q;
              app_ref_d = reference_select_q;
              acc_d     = 16'h0000;
              samp_d    = 7'd0;
              if (continuous_mode_bit_q && !stop_d) begin
                state_d = ACS_CONV;
              end else begin
                start_conversion_bit_d = 1'b0;
                stop_d   = 1'b0;
                state_d  = ACS_IDLE;
              end
            end else if (dly_new != 5'h00) begin
              dly_d   = dly_new;
              state_d = ACS_DELAY;
            end
          end
        end
      end
      ACS_DELAY: begin
        if (tick) begin
          dly_d = 5'(dly_q - 5'h01);
          if (dly_q == 5'h01) state_d = ACS_CONV;
        end
      end
    endcase
    // Disabling drops any conversion at once
    if (!enable_q) begin
      state_d  = ACS_IDLE;
      start_conversion_bit_d = 1'b0;
      stop_d   = 1'b0;
    end
    irq_d = gie && |(flag_q & inten_q);
  end

  // Sequencer registers and event synchroniser
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      state_q         <= ACS_IDLE;
      start_conversion_bit_q        <= 1'b0;
      stop_q          <= 1'b0;
      done_q          <= 1'b0;
      flag_q          <= 2'h0;
      res_q           <= 16'h0000;
      acc_q           <= 16'h0000;
      tcnt_q          <= 4'h0;
      samp_q          <= 7'd0;
      dly_q           <= 5'h00;
      lfsr_q          <= ACS_LFSR_RST;
      applied_channel <= ACS_MUX_RST;
      applied_ref     <= ACS_REFERENCE_SELECT_RST;
      converter_on    <= 1'b0;
      sample_hold     <= 1'b0;
      irq             <= 1'b0;
      evt_s1          <= 1'b0;
      evt_s2          <= 1'b0;
      evt_s3          <= 1'b0;
    end else if (ce) begin
      state_q         <= state_d;
      start_conversion_bit_q        <= start_conversion_bit_d;
      stop_q          <= stop_d;
      done_q          <= done_d;
      flag_q          <= flag_d;
      res_q           <= res_d;
      acc_q           <= acc_d;
      tcnt_q          <= tcnt_d;
      samp_q          <= samp_d;
      dly_q           <= dly_d;
      lfsr_q          <= lfsr_d;
      applied_channel <= app_ch_d;
      applied_ref     <= app_ref_d;
      converter_on    <= enable_d;
      sample_hold     <= sh_d;
      irq             <= irq_d;
      evt_s1          <= trig_evt;
      evt_s2          <= evt_s1;
      evt_s3          <= evt_s2;
    end
  end

  // APB answer: no wait states, read data latched in the setup cycle
  always_comb begin
    pready_d  = psel && !penable;
    pslverr_d = 1'b0;
    prdata_d  = 32'h0000_0000;
    unique case (paddr)
      ACS_OFF_CTRL:    prdata_d = {29'h0, resolution_select_q, continuous_mode_bit_q, enable_q};
      ACS_OFF_ACCUM:   prdata_d = {23'h0, random_q, sampdly_q, 1'b0, accum_q};
      ACS_OFF_CLKREF:  prdata_d = {25'h0, clock_divider_select_q, 2'h0, reference_select_q};
      ACS_OFF_MUX:     prdata_d = {27'h0, input_channel_select_q};
      ACS_OFF_EVCTRL:  prdata_d = {31'h0, trigger_event_input_enable_q};
      ACS_OFF_INTEN:   prdata_d = {30'h0, inten_q};
      ACS_OFF_COMMAND: prdata_d = {31'h0, start_conversion_bit_q};
      ACS_OFF_INTERRUPT_FLAG_REGISTER: prdata_d = {30'h0, flag_q};
      ACS_OFF_RESULT:  prdata_d = {16'h0, res_q};
      ACS_OFF_WINLO:   prdata_d = {16'h0, winlo_q};
      ACS_OFF_WINHI:   prdata_d = {16'h0, winhi_q};
      ACS_OFF_WINMODE: prdata_d = {29'h0, winmode_q};
      ACS_OFF_STATUS:  prdata_d = {15'h0, start_conversion_bit_q, 6'h0, applied_ref, 3'h0, applied_channel};
      default:         pslverr_d = psel && !penable;  // Unmapped address
    endcase
  end

  // APB registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (psel && !penable) prdata <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  a_result_aligned: assert property (@(posedge mclk) disable iff (!resetn)
    (done_q && accum_q == 3'h0) |-> res_q[15:10] == 6'h00)
    else $error("Single result not right aligned");
  a_idle_disabled: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && !enable_q) |=> (state_q == ACS_IDLE && !start_conversion_bit_q))
    else $error("Sequencer active while disabled");
  a_busy_reads_one: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q != ACS_IDLE) |-> start_conversion_bit_q)
    else $error("Start bit low during conversion");
  a_single_clears: assert property (@(posedge mclk) disable iff (!resetn)
    (done_q && !continuous_mode_bit_q) |-> (!start_conversion_bit_q && state_q == ACS_IDLE))
    else $error("Single conversion left start bit set");
  a_channel_locked: assert property (@(posedge mclk) disable iff (!resetn)
    (state_q != ACS_IDLE && $past(state_q) != ACS_IDLE && !done_q) |-> $stable(applied_channel))
    else $error("Channel changed mid conversion");
  a_flag_on_done: assert property (@(posedge mclk) disable iff (!resetn)
    done_q |-> flag_q[ACS_BIT_RESULT_READY_FLAG])
    else $error("Ready flag not set on completion");
  a_irq_gating: assert property (@(posedge mclk) disable iff (!resetn)
    $past(ce) |-> irq == $past(gie && |(flag_q & inten_q)))
    else $error("Interrupt not gated by flag and enables");
  a_event_starts: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && enable_q && trigger_event_input_enable_q && state_q == ACS_IDLE && evt_s2 && !evt_s3)
    |=> (start_conversion_bit_q && state_q == ACS_ARM))
    else $error("Event edge did not start a conversion");
  a_continuous_mode_bit_restart: assert property (@(posedge mclk) disable iff (!resetn)
    (done_q && start_conversion_bit_q) |-> state_q == ACS_CONV)
    else $error("Continuous mode did not restart");
  a_busy_ignores: assert property (@(posedge mclk) disable iff (!resetn)
    (ce && state_q == ACS_CONV && enable_q && !tick) |=> state_q == ACS_CONV)
    else $error("Busy conversion disturbed");
endmodule

// [sim/acs_conv_model.sv]
// Behavioural converter front end feeding the sequencer a code per channel
`timescale 1ns/1ps
module acs_conv_model (
  input  wire logic [4:0] applied_channel,  // Channel from the input mux
  input  wire logic [1:0] applied_ref,      // Reference now applied
  input  wire logic       converter_on,     // Analog power enable
  output logic      [9:0] conv_data         // Code to the sequencer
);
  logic [9:0] code;  // Code that names channel and reference
  // Code encodes channel and reference, so a wrong mux setting shows in the result
  assign code = {applied_channel, applied_ref, 3'h5};
  // Powered down means no valid code, so drive the inverse rather than a stale value
  assign conv_data = converter_on ? code : ~code;
endmodule

// [sim/adc_conversion_sequencer_test.sv]
// Self-checking bench for the conversion sequencer
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
  import acs_pkg::*;
  logic mclk, resetn, ce, psel, penable, pwrite, pready, pslverr, trig_evt, gie;
  logic        converter_on, sample_hold, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [9:0]  conv_data;
  logic [4:0]  applied_channel;
  logic [1:0]  applied_ref;
  int          err_total, cmp_count, sh_cnt, cyc;
  acs_seq u_acs_seq (.mclk(mclk), .resetn(resetn), .ce(ce), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .trig_evt(trig_evt), .gie(gie), .conv_data(conv_data),
    .applied_channel(applied_channel), .applied_ref(applied_ref),
    .converter_on(converter_on), .sample_hold(sample_hold), .irq(irq));
  acs_conv_model u_acs_conv_model (.applied_channel(applied_channel),
    .applied_ref(applied_ref), .converter_on(converter_on), .conv_data(conv_data));
  // Clock at 100 MHz
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Sample-and-hold pulse counter and hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (sample_hold === 1'b1) sh_cnt <= sh_cnt + 1;
    if (cyc == 40000) begin
      err_total++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      err_total++;
    end
  endtask
  // One APB transfer; request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge mclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Only pready high or the bench timeout ends this wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask
  // Poll the start bit until it drops
  task automatic wait_idle();
    logic [31:0] q;
    do begin
      rd(ACS_OFF_COMMAND, q);
    end while (q[0] !== 1'b0);
  endtask
  task automatic wait_sh(input int b, input int k);
    while (sh_cnt - b < k) @(posedge mclk);
  endtask
  task automatic pulse_trig();
    @(posedge mclk) trig_evt <= 1'b1;
    repeat (5) @(posedge mclk);
    trig_evt <= 1'b0;
  endtask
  // Expected code from the converter model, reference kept internal
  function automatic logic [31:0] val(input logic [4:0] ch);
    return {22'h0, ch, 2'h0, 3'h5};
  endfunction
  task automatic t_reset();
    logic [31:0] q;
    logic        e;
    rd(ACS_OFF_CLKREF, q);
    chk(q, 32'h0);
    chk({30'h0, applied_ref}, 32'h0);
    apb(1'b0, 8'h3c, 32'h0, q, e);
    chk({31'h0, e}, 32'h1);
    chk(q, 32'h0);
    wr(ACS_OFF_MUX, 32'h5);
    wr(ACS_OFF_COMMAND, 32'h1);
    rd(ACS_OFF_COMMAND, q);
    chk(q, 32'h0);
    chk({27'h0, applied_channel, converter_on}, 32'h0);
    wr(ACS_OFF_CLKREF, 32'h2);
    wr(ACS_OFF_CTRL, 32'h1);
    repeat (3) @(posedge mclk);
    chk({25'h0, applied_channel, applied_ref}, 32'h16);
    wr(ACS_OFF_CLKREF, 32'h0);
  endtask
  // Single conversion: timing, busy bit, lock of channel, ignored restart, interrupt gating
  task automatic t_single();
    logic [31:0] q;
    int          b, d;
    realtime     t0;
    wr(ACS_OFF_MUX, 32'h3);
    wr(ACS_OFF_INTEN, 32'h1);
    gie <= 1'b1;
    repeat (3) @(posedge mclk);
    b = sh_cnt;
    wr(ACS_OFF_COMMAND, 32'h1);
    t0 = $realtime;
    rd(ACS_OFF_COMMAND, q);
    chk(q, 32'h1);
    wr(ACS_OFF_MUX, 32'h7);
    wr(ACS_OFF_COMMAND, 32'h1);
    while (irq !== 1'b1) @(posedge mclk);
    d = int'(($realtime - t0) / 10.0);
    chk({31'h0, d >= 25 && d <= 33}, 32'h1);
    chk(32'(sh_cnt - b), 32'h1);
    ce  <= 1'b0;
    gie <= 1'b0;
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    ce  <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    gie <= 1'b1;
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    wr(ACS_OFF_INTEN, 32'h0);
    repeat (3) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rd(ACS_OFF_COMMAND, q);
    chk(q, 32'h0);
    rd(ACS_OFF_RESULT, q);
    chk(q, val(5'h3));
    chk({27'h0, applied_channel}, 32'h7);
    rd(ACS_OFF_INTERRUPT_FLAG_REGISTER, q);
    chk(q & 32'h1, 32'h0);
  endtask
  task automatic t_event();
    logic [31:0] q;
    int          b;
    wr(ACS_OFF_EVCTRL, 32'h1);
    pulse_trig();
    rd(ACS_OFF_COMMAND, q);
    chk(q, 32'h1);
    wait_idle();
    rd(ACS_OFF_INTERRUPT_FLAG_REGISTER, q);
    chk(q & 32'h1, 32'h1);
    wr(ACS_OFF_INTERRUPT_FLAG_REGISTER, 32'h1);
    rd(ACS_OFF_INTERRUPT_FLAG_REGISTER, q);
    chk(q & 32'h1, 32'h0);
    wr(ACS_OFF_EVCTRL, 32'h0);
    b = sh_cnt;
    pulse_trig();
    repeat (40) @(posedge mclk);
    chk(32'(sh_cnt - b), 32'h0);
  endtask
  // Burst of four: flag only at the end, sum of samples, delay stretches the burst
  task automatic t_accum();
    logic [31:0] q;
    int          b;
    realtime     t0, t1, t2;
    wr(ACS_OFF_ACCUM, 32'h2);
    b = sh_cnt;
    t0 = $realtime;
    wr(ACS_OFF_COMMAND, 32'h1);
    wait_sh(b, 2);
    rd(ACS_OFF_INTERRUPT_FLAG_REGISTER, q);
    chk(q & 32'h1, 32'h0);
    wait_idle();
    t1 = $realtime - t0;
    chk(32'(sh_cnt - b), 32'h4);
    rd(ACS_OFF_INTERRUPT_FLAG_REGISTER, q);
    chk(q & 32'h1, 32'h1);
    rd(ACS_OFF_RESULT, q);
    chk(q, val(5'h7) << 2);
    wr(ACS_OFF_ACCUM, 32'h82);
    t0 = $realtime;
    wr(ACS_OFF_COMMAND, 32'h1);
    wait_idle();
    t2 = $realtime - t0;
    chk({31'h0, t2 > t1 + 200.0}, 32'h1);
    // Random delay alone, fixed delay zero: burst still whole and sum unchanged
    wr(ACS_OFF_ACCUM, 32'h102);
    b = sh_cnt;
    wr(ACS_OFF_COMMAND, 32'h1);
    wait_idle();
    chk(32'(sh_cnt - b), 32'h4);
    rd(ACS_OFF_RESULT, q);
    chk(q, val(5'h7) << 2);
    wr(ACS_OFF_ACCUM, 32'h0);
    rd(ACS_OFF_RESULT, q);
  endtask
  // Each of the four compare modes other than off against a window that lies above the result
  task automatic t_window();
    logic [31:0] q;
    wr(ACS_OFF_WINLO, val(5'h7) + 32'h1);
    wr(ACS_OFF_WINHI, val(5'h7) + 32'ha);
    for (int m = 1; m <= 4; m++) begin
      wr(ACS_OFF_WINMODE, 32'(m));
      wr(ACS_OFF_INTERRUPT_FLAG_REGISTER, 32'h3);
      wr(ACS_OFF_COMMAND, 32'h1);
      wait_idle();
      rd(ACS_OFF_INTERRUPT_FLAG_REGISTER, q);
      chk(q & 32'h2, (m == 1 || m == 4) ? 32'h2 : 32'h0);
    end
    wr(ACS_OFF_WINMODE, 32'h0);
  endtask
  task automatic t_cont();
    logic [31:0] q;
    int          b;
    wr(ACS_OFF_CTRL, 32'h3);
    wr(ACS_OFF_INTERRUPT_FLAG_REGISTER, 32'h3);
    b = sh_cnt;
    wr(ACS_OFF_COMMAND, 32'h1);
    wait_sh(b, 3);
    rd(ACS_OFF_INTERRUPT_FLAG_REGISTER, q);
    chk(q & 32'h1, 32'h1);
    rd(ACS_OFF_RESULT, q);
    wait_sh(b, 5);
    rd(ACS_OFF_INTERRUPT_FLAG_REGISTER, q);
    chk(q & 32'h1, 32'h1);
    rd(ACS_OFF_COMMAND, q);
    chk(q, 32'h1);
    wr(ACS_OFF_COMMAND, 32'h0);
    wait_idle();
    b = sh_cnt;
    repeat (60) @(posedge mclk);
    chk(32'(sh_cnt - b), 32'h0);
  endtask
  // Main sequence
  initial begin
    resetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
    pwdata = 32'h0; trig_evt = 1'b0; gie = 1'b0; ce = 1'b1;
    err_total = 0; cmp_count = 0; sh_cnt = 0; cyc = 0;
    repeat (5) @(posedge mclk);
    resetn <= 1'b1;
    t_reset();
    t_single();
    t_event();
    t_accum();
    t_window();
    t_cont();
    stop_test();
  end
endmodule
